// [fic_controller.sv]
// Five-level interrupt controller with AHB-Lite register slave
`timescale 1ns/1ps
module fic_controller
  import fic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [FIC_NUM_EXT-1:0] ext_irq_n_pin,
  input wire logic powerfail_warn,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic timer2_external,
  input wire logic serial0_receive,
  input wire logic serial0_transmit,
  input wire logic serial1_receive,
  input wire logic serial1_transmit,
  input wire logic watchdog_timeout,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_request,
  output logic [7:0] irq_vector,
  output logic [FIC_LVL_W-1:0] irq_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fic_state_t s;
  fic_state_t next_s;

  logic global_irq_enable;
  logic powerfail_irq_enable;
  logic [FIC_NUM_SRC-2:0] en12;
  logic [FIC_NUM_SRC-2:0] lo12;
  logic [FIC_NUM_SRC-2:0] hi12;
  logic [FIC_NUM_SRC-1:0] src_raw;
  logic [FIC_NUM_SRC-1:0] src_req;
  logic [FIC_NUM_SRC*FIC_LVL_W-1:0] src_lvl;
  logic [FIC_LVL_W-1:0] cur_rank;
  logic win_valid;
  logic [FIC_IDX_W-1:0] win_idx;
  logic [FIC_LVL_W-1:0] win_lvl;
  logic addr_phase;
  logic [FIC_NUM_FLG-1:0] set_f;
  logic [FIC_NUM_FLG-1:0] clr_sw;
  logic [FIC_NUM_FLG-1:0] clr_hw;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  assign global_irq_enable = s.irq_enable[FIC_GLOBAL_EN_BIT];
  assign powerfail_irq_enable = s.control[FIC_CTL_PFEN];
  // Sources 1..12 take enable and priority bits in natural order
  assign en12 = {s.extended_irq_enable_reg, s.irq_enable[6:0]};
  assign lo12 = {s.ext_priority_low_bits_reg, s.priority_low_bits_reg};
  assign hi12 = {s.ext_priority_high_bits_reg, s.priority_high_bits_reg};

  // Raw requests in natural order, shared flags ORed
  assign src_raw = {
    s.flags[FIC_FLG_WD],
    s.flags[FIC_FLG_EXT0+5],
    s.flags[FIC_FLG_EXT0+4],
    s.flags[FIC_FLG_EXT0+3],
    s.flags[FIC_FLG_EXT0+2],
    s.flags[FIC_FLG_S1RX] | s.flags[FIC_FLG_S1TX],
    s.flags[FIC_FLG_T2OV] | s.flags[FIC_FLG_T2EX],
    s.flags[FIC_FLG_S0RX] | s.flags[FIC_FLG_S0TX],
    s.flags[FIC_FLG_T1],
    s.flags[FIC_FLG_EXT0+1],
    s.flags[FIC_FLG_T0],
    s.flags[FIC_FLG_EXT0],
    s.flags[FIC_FLG_PF]};

  // Power fail: own enable only, fixed top level
  assign src_req[0] = src_raw[0] & powerfail_irq_enable;
  assign src_lvl[0 +: FIC_LVL_W] = FIC_LVL_PF;

  for (genvar i = 1; i < FIC_NUM_SRC; i++) begin : g_src
    // Series gating by own and global enable
    assign src_req[i] = src_raw[i] & en12[i-1] & global_irq_enable;
    // Level 0..3 from high and low bit
    assign src_lvl[i*FIC_LVL_W +: FIC_LVL_W] = {1'b0, hi12[i-1], lo12[i-1]};
  end

  // ----------------------------------------------------------------
  // Level in service and winner
  // ----------------------------------------------------------------
  always_comb begin
    cur_rank = '0;
    for (int k = 0; k < FIC_NUM_LVL; k++) begin
      if (s.in_service[k]) begin
        cur_rank = FIC_LVL_W'(k + 1);
      end
    end
  end

  // Highest level first, natural order on ties, strictly above service
  fic_resolver #(
    .N(FIC_NUM_SRC),
    .LW(FIC_LVL_W),
    .IW(FIC_IDX_W)
  ) u_resolver (
    .req(src_req),
    .lvl(src_lvl),
    .floor_rank(cur_rank),
    .valid(win_valid),
    .idx(win_idx),
    .level(win_lvl)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[FIC_ADDR_W-1:0])
      FIC_OFS_ENABLE: rd_word[7:0] = s.irq_enable;
      FIC_OFS_EXT_ENABLE: rd_word[4:0] = s.extended_irq_enable_reg;
      FIC_OFS_PRIO_LOW: rd_word[6:0] = s.priority_low_bits_reg;
      FIC_OFS_PRIO_HIGH: rd_word[6:0] = s.priority_high_bits_reg;
      FIC_OFS_EXT_PRIO_LOW: rd_word[4:0] = s.ext_priority_low_bits_reg;
      FIC_OFS_EXT_PRIO_HIGH: rd_word[4:0] = s.ext_priority_high_bits_reg;
      FIC_OFS_FLAGS: rd_word[FIC_NUM_FLG-1:0] = s.flags;
      FIC_OFS_CONTROL: rd_word[2:0] = s.control;
      FIC_OFS_STATUS: rd_word = {7'h00, s.req, 5'h00, s.level, s.vector, 3'h0, s.in_service};
      FIC_OFS_PENDING: rd_word[FIC_NUM_SRC-1:0] = src_req;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Write-one-to-clear flags, data phase only
  always_comb begin
    clr_sw = '0;
    if (s.ph_valid && s.ph_write && (s.ph_addr == FIC_OFS_FLAGS)) begin
      clr_sw = hwdata[FIC_NUM_FLG-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  always_comb begin
    set_f = '0;
    // Flags set on their event regardless of enables
    set_f[FIC_FLG_PF] = s.pf_s2 & ~s.pf_d;
    for (int e = 0; e < FIC_NUM_EXT; e++) begin
      set_f[FIC_FLG_EXT0+e] = s.ext_d[e] & ~s.ext_s2[e];
    end
    set_f[FIC_FLG_T0] = timer0_overflow;
    set_f[FIC_FLG_T1] = timer1_overflow;
    set_f[FIC_FLG_T2OV] = timer2_overflow;
    set_f[FIC_FLG_T2EX] = timer2_external;
    set_f[FIC_FLG_S0RX] = serial0_receive;
    set_f[FIC_FLG_S0TX] = serial0_transmit;
    set_f[FIC_FLG_S1RX] = serial1_receive;
    set_f[FIC_FLG_S1TX] = serial1_transmit;
    set_f[FIC_FLG_WD] = watchdog_timeout;
  end

  // Hardware clears on vectoring
  always_comb begin
    clr_hw = '0;
    if (irq_ack && s.req) begin
      unique case (s.win_idx)
        FIC_SRC_EXT0: clr_hw[FIC_FLG_EXT0] = s.control[FIC_CTL_EDGE0];
        FIC_SRC_EXT1: clr_hw[FIC_FLG_EXT0+1] = s.control[FIC_CTL_EDGE1];
        FIC_SRC_T0: clr_hw[FIC_FLG_T0] = 1'b1;
        FIC_SRC_T1: clr_hw[FIC_FLG_T1] = 1'b1;
        default: clr_hw = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Pin synchronisers and edge history
    next_s.ext_s1 = ext_irq_n_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_d = s.ext_s2;
    next_s.pf_s1 = powerfail_warn;
    next_s.pf_s2 = s.pf_s1;
    next_s.pf_d = s.pf_s2;

    // Register writes in the data phase
    if (s.ph_valid && s.ph_write) begin
      unique case (s.ph_addr)
        FIC_OFS_ENABLE: next_s.irq_enable = hwdata[7:0];
        FIC_OFS_EXT_ENABLE: next_s.extended_irq_enable_reg = hwdata[4:0];
        FIC_OFS_PRIO_LOW: next_s.priority_low_bits_reg = hwdata[6:0];
        FIC_OFS_PRIO_HIGH: next_s.priority_high_bits_reg = hwdata[6:0];
        FIC_OFS_EXT_PRIO_LOW: next_s.ext_priority_low_bits_reg = hwdata[4:0];
        FIC_OFS_EXT_PRIO_HIGH: next_s.ext_priority_high_bits_reg = hwdata[4:0];
        FIC_OFS_CONTROL: next_s.control = hwdata[2:0];
        default: next_s.control = s.control;
      endcase
    end

    // Sticky flags, set wins over any clear
    next_s.flags = (s.flags & ~(clr_sw | clr_hw)) | set_f;
    // Level mode: flag mirrors the active-low pin
    if (!s.control[FIC_CTL_EDGE0]) begin
      next_s.flags[FIC_FLG_EXT0] = ~s.ext_s2[0];
    end
    if (!s.control[FIC_CTL_EDGE1]) begin
      next_s.flags[FIC_FLG_EXT0+1] = ~s.ext_s2[1];
    end

    // Return from service frees the highest level in service
    if (irq_return && (cur_rank != '0)) begin
      next_s.in_service[cur_rank - 3'h1] = 1'b0;
    end
    // Vectoring enters the level that the core was offered
    if (irq_ack && s.req) begin
      next_s.in_service[s.level] = 1'b1;
    end

    // Offer to the core; dropped for one cycle after an acknowledge
    next_s.req = win_valid & ~irq_ack;
    if (win_valid) begin
      next_s.vector = FIC_VEC[win_idx];
      next_s.level = win_lvl;
      next_s.win_idx = win_idx;
    end

    // Bus address phase capture and read data
    next_s.ph_valid = addr_phase;
    next_s.ph_write = hwrite;
    next_s.ph_addr = haddr[FIC_ADDR_W-1:0];
    if (addr_phase && !hwrite) begin
      next_s.rdata = rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= FIC_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign irq_request = s.req;
  assign irq_vector = s.vector;
  assign irq_level = s.level;

endmodule

// [fic_controller_asserts.sv]
// Port-level checker for the interrupt controller
`timescale 1ns/1ps
module fic_controller_asserts
  import fic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_request,
  input wire logic [7:0] irq_vector,
  input wire logic [FIC_LVL_W-1:0] irq_level
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Highest level taken, forgotten on any return
  // ----------------------------------------------------------------
  logic svc_v;
  logic [FIC_LVL_W-1:0] svc_l;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_v <= 1'b0;
      svc_l <= '0;
    end else if (irq_ack && irq_request) begin
      svc_v <= 1'b1;
      svc_l <= irq_level;
    end else if (irq_return) begin
      svc_v <= 1'b0;
    end
  end
  sequence s_ack(v);
    irq_ack && irq_request && irq_vector == v;
  endsequence
  property p_autoclr(v, src);
    (s_ack(v) ##0 !src) ##1 (!src)[*4] |-> !(irq_request && irq_vector == v);
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_ack_drop: assert property (irq_ack && irq_request |=> !irq_request)
    else $error("offer stayed up after ack");
  chk_pf_level: assert property (irq_request |-> ((irq_vector == 8'h33) == (irq_level == FIC_LVL_PF)))
    else $error("power fail and level 4 disagree");
  chk_lvl_range: assert property (irq_request |-> irq_level <= 3'h4)
    else $error("offered level out of range");
  chk_vec_legal: assert property (irq_request |-> irq_vector inside {8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B,
    8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63})
    else $error("offered vector not a known vector");
  chk_preempt_up: assert property (svc_v && irq_request |-> irq_level > svc_l)
    else $error("offer not above level in service");
  chk_t0_clear: assert property (p_autoclr(8'h0B, timer0_overflow))
    else $error("timer 0 offered again after vectoring");
  chk_t1_clear: assert property (p_autoclr(8'h1B, timer1_overflow))
    else $error("timer 1 offered again after vectoring");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
endmodule
bind fic_controller fic_controller_asserts fic_controller_asserts_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow), .irq_ack(irq_ack),
  .irq_return(irq_return), .irq_request(irq_request), .irq_vector(irq_vector), .irq_level(irq_level));

// [fic_core_model.sv]
// Core-side partner: acknowledges offered vectors and returns after a service time
`timescale 1ns/1ps
module fic_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_request,
  input wire logic ack_en,
  input wire logic [7:0] svc_len,
  output logic irq_ack,
  output logic irq_return
);
  logic [3:0] depth;
  logic [7:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      depth <= 4'h0;
      cnt <= 8'h00;
    end else begin
      // One-cycle ack, only against a standing offer
      irq_ack <= ack_en && irq_request && !irq_ack;
      irq_return <= 1'b0;
      if (irq_ack && irq_request) begin
        depth <= depth + 4'h1;
        cnt <= svc_len;
      end else if (depth != 4'h0) begin
        if (cnt == 8'h00) begin
          irq_return <= 1'b1;
          depth <= depth - 4'h1;
          cnt <= svc_len;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule

// [fic_pkg.sv]
// Constants, register map and state type of the five-level interrupt controller
package fic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int FIC_NUM_SRC = 13;
  localparam int FIC_NUM_LVL = 5;
  localparam int FIC_LVL_W = 3;
  localparam int FIC_IDX_W = 4;
  localparam int FIC_NUM_EXT = 6;
  localparam int FIC_NUM_FLG = 16;
  localparam int FIC_ADDR_W = 8;

  // ----------------------------------------------------------------
  // Source indices, natural order, and the fixed power-fail level
  // ----------------------------------------------------------------
  localparam logic [FIC_IDX_W-1:0] FIC_SRC_PF = 4'h0;
  localparam logic [FIC_IDX_W-1:0] FIC_SRC_EXT0 = 4'h1;
  localparam logic [FIC_IDX_W-1:0] FIC_SRC_T0 = 4'h2;
  localparam logic [FIC_IDX_W-1:0] FIC_SRC_EXT1 = 4'h3;
  localparam logic [FIC_IDX_W-1:0] FIC_SRC_T1 = 4'h4;
  localparam logic [FIC_LVL_W-1:0] FIC_LVL_PF = 3'h4;

  // Vector addresses in natural order
  localparam logic [7:0] FIC_VEC [FIC_NUM_SRC] = '{
    8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B,
    8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int FIC_FLG_PF = 0;
  localparam int FIC_FLG_EXT0 = 1;
  localparam int FIC_FLG_T0 = 7;
  localparam int FIC_FLG_T1 = 8;
  localparam int FIC_FLG_T2OV = 9;
  localparam int FIC_FLG_T2EX = 10;
  localparam int FIC_FLG_S0RX = 11;
  localparam int FIC_FLG_S0TX = 12;
  localparam int FIC_FLG_S1RX = 13;
  localparam int FIC_FLG_S1TX = 14;
  localparam int FIC_FLG_WD = 15;

  // Control register bits, and the global enable bit of the enable register
  localparam int FIC_CTL_PFEN = 0;
  localparam int FIC_CTL_EDGE0 = 1;
  localparam int FIC_CTL_EDGE1 = 2;
  localparam int FIC_GLOBAL_EN_BIT = 7;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_ENABLE = 8'h00;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_EXT_ENABLE = 8'h04;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_PRIO_LOW = 8'h08;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_PRIO_HIGH = 8'h0C;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_EXT_PRIO_LOW = 8'h10;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_EXT_PRIO_HIGH = 8'h14;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_FLAGS = 8'h18;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_CONTROL = 8'h1C;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_STATUS = 8'h20;
  localparam logic [FIC_ADDR_W-1:0] FIC_OFS_PENDING = 8'h24;

  // ----------------------------------------------------------------
  // State of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [FIC_NUM_EXT-1:0] ext_s1;
    logic [FIC_NUM_EXT-1:0] ext_s2;
    logic [FIC_NUM_EXT-1:0] ext_d;
    logic pf_s1;
    logic pf_s2;
    logic pf_d;
    logic [7:0] irq_enable;
    logic [4:0] extended_irq_enable_reg;
    logic [6:0] priority_low_bits_reg;
    logic [6:0] priority_high_bits_reg;
    logic [4:0] ext_priority_low_bits_reg;
    logic [4:0] ext_priority_high_bits_reg;
    logic [2:0] control;
    logic [FIC_NUM_FLG-1:0] flags;
    logic [FIC_NUM_LVL-1:0] in_service;
    logic req;
    logic [7:0] vector;
    logic [FIC_LVL_W-1:0] level;
    logic [FIC_IDX_W-1:0] win_idx;
    logic ph_valid;
    logic ph_write;
    logic [FIC_ADDR_W-1:0] ph_addr;
    logic [31:0] rdata;
  } fic_state_t;

  // Pins idle high, so synchronisers start high
  localparam logic [FIC_NUM_EXT-1:0] FIC_EXT_SYNC_RST = 6'h3F;
  localparam fic_state_t FIC_STATE_RST = '{
    ext_s1: FIC_EXT_SYNC_RST, ext_s2: FIC_EXT_SYNC_RST, ext_d: FIC_EXT_SYNC_RST, default: '0};

endpackage

// [fic_resolver.sv]
// Priority resolver: highest level wins, natural order breaks ties
`timescale 1ns/1ps
module fic_resolver #(
  parameter int N = 13,
  parameter int LW = 3,
  parameter int IW = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [N*LW-1:0] lvl,
  input wire logic [LW-1:0] floor_rank,
  output logic valid,
  output logic [IW-1:0] idx,
  output logic [LW-1:0] level
);

  // Rank is level plus one; floor_rank is the rank in service, zero when idle
  always_comb begin
    logic [LW-1:0] best;
    logic [LW-1:0] rank;
    best = floor_rank;
    rank = '0;
    valid = 1'b0;
    idx = '0;
    level = '0;
    for (int i = 0; i < N; i++) begin
      rank = lvl[i*LW +: LW] + {{(LW-1){1'b0}}, 1'b1};
      // Strictly greater: earlier source keeps a tie, equal level never preempts
      if (req[i] && (rank > best)) begin
        best = rank;
        valid = 1'b1;
        idx = IW'(i);
        level = lvl[i*LW +: LW];
      end
    end
  end

endmodule

// [tb_top.sv]
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
  import fic_pkg::*;
  typedef struct packed {
    logic [8:0] p;
    logic [7:0] en;
    logic [4:0] een;
    logic [6:0] lo;
    logic [6:0] hi;
    logic r;
    logic [7:0] v;
    logic [2:0] l;
  } fic_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pfw, ack_en, irq_ack, irq_return, irq_request;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_level;
  logic [5:0] pins;
  logic [8:0] pul;
  logic [7:0] irq_vector, svc_len;
  int fails, checked;
  int cyc = 0;
  // Pulses: wd, s1tx, s1rx, s0tx, s0rx, t2ex, t2ov, t1, t0
  fic_row_t rows [9] = '{
    '{9'h001, 8'h82, 0, 0, 0, 1, 8'h0B, 0}, '{9'h001, 8'h02, 0, 0, 0, 0, 8'h00, 0},
    '{9'h003, 8'h8A, 0, 0, 7'h08, 1, 8'h1B, 2}, '{9'h003, 8'h8A, 0, 0, 0, 1, 8'h0B, 0},
    '{9'h020, 8'h90, 0, 0, 0, 1, 8'h23, 0}, '{9'h090, 8'hD0, 0, 7'h40, 0, 1, 8'h3B, 1},
    '{9'h004, 8'hA0, 0, 0, 0, 1, 8'h2B, 0}, '{9'h108, 8'hA0, 5'h10, 0, 0, 1, 8'h2B, 0},
    '{9'h100, 8'h80, 5'h10, 0, 0, 1, 8'h63, 0}};
  assign hready = hreadyout;
  fic_controller fic_controller_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_irq_n_pin(pins), .powerfail_warn(pfw),
    .timer0_overflow(pul[0]), .timer1_overflow(pul[1]), .timer2_overflow(pul[2]), .timer2_external(pul[3]),
    .serial0_receive(pul[4]), .serial0_transmit(pul[5]), .serial1_receive(pul[6]),
    .serial1_transmit(pul[7]), .watchdog_timeout(pul[8]), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_request(irq_request), .irq_vector(irq_vector), .irq_level(irq_level));
  fic_core_model fic_core_model_inst (.hclk(hclk), .hresetn(hresetn), .irq_request(irq_request),
    .ack_en(ack_en), .svc_len(svc_len), .irq_ack(irq_ack), .irq_return(irq_return));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(x & m, e);
  endtask
  task automatic pulse(input logic [8:0] p);
    pul <= p;
    @(posedge hclk);
    pul <= '0;
    @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout, stimulus
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, pfw, ack_en, haddr, hwdata, htrans, pul, fails, checked} = '0;
    hsize = 3'h2;
    pins = 6'h3F;
    svc_len = 8'h03;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 40; a += 4) rc(8'(a), 32'hFFFFFFFF, 32'h0);
    wr(8'h28, 32'hFFFFFFFF);
    rc(8'h28, 32'hFFFFFFFF, 32'h0);
    foreach (rows[i]) begin
      wr(8'h00, rows[i].en);
      wr(8'h04, rows[i].een);
      wr(8'h08, rows[i].lo);
      wr(8'h0C, rows[i].hi);
      pulse(rows[i].p);
      repeat (3) @(posedge hclk);
      rc(8'h20, rows[i].r ? 32'h0107FF1F : 32'h0100001F, {7'h0, rows[i].r, 5'h0, rows[i].l, rows[i].v, 8'h0});
      chk(irq_request, rows[i].r);
      if (rows[i].r) chk({irq_level, irq_vector}, {rows[i].l, rows[i].v});
      wr(8'h18, 32'hFFFF);
      wr(8'h00, 32'h0);
    end
    // Flags set while disabled, then software clear
    pins <= 6'h3B;
    pulse(9'h001);
    repeat (3) @(posedge hclk);
    pins <= 6'h3F;
    rc(8'h18, 32'hFFFF, 32'h0088);
    wr(8'h18, 32'h0088);
    rc(8'h18, 32'hFFFF, 32'h0);
    // Power fail ignores global enable and outranks level 3
    wr(8'h1C, 32'h1);
    wr(8'h00, 32'h02);
    wr(8'h08, 32'h02);
    wr(8'h0C, 32'h02);
    pulse(9'h001);
    pfw <= 1'b1;
    repeat (6) @(posedge hclk);
    rc(8'h20, 32'h0107FF00, 32'h01043300);
    wr(8'h00, 32'h82);
    rc(8'h20, 32'h0107FF00, 32'h01043300);
    pfw <= 1'b0;
    repeat (4) @(posedge hclk);
    rc(8'h18, 32'h1, 32'h1);
    wr(8'h18, 32'hFFFF);
    wr(8'h1C, 32'h0);
    wr(8'h0C, 32'h0);
    // Vectoring, auto clear and nesting
    svc_len <= 8'd60;
    ack_en <= 1'b1;
    wr(8'h08, 32'h08);
    wr(8'h00, 32'h8A);
    pulse(9'h001);
    repeat (6) @(posedge hclk);
    rc(8'h18, 32'hFFFF, 32'h0);
    rc(8'h20, 32'h1F, 32'h01);
    pulse(9'h001);
    repeat (4) @(posedge hclk);
    rc(8'h20, 32'h0100001F, 32'h01);
    pulse(9'h002);
    repeat (6) @(posedge hclk);
    rc(8'h20, 32'h0100001F, 32'h03);
    rc(8'h18, 32'hFFFF, 32'h0080);
    repeat (250) @(posedge hclk);
    rc(8'h20, 32'h0100001F, 32'h0);
    rc(8'h18, 32'hFFFF, 32'h0);
    ack_en <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    // External 0 in level mode, then edge mode
    pins <= 6'h3E;
    repeat (5) @(posedge hclk);
    rc(8'h18, 32'h2, 32'h2);
    pins <= 6'h3F;
    repeat (5) @(posedge hclk);
    rc(8'h18, 32'h2, 32'h0);
    wr(8'h1C, 32'h2);
    pins <= 6'h3E;
    repeat (5) @(posedge hclk);
    pins <= 6'h3F;
    rc(8'h18, 32'h2, 32'h2);
    svc_len <= 8'h03;
    ack_en <= 1'b1;
    wr(8'h00, 32'h81);
    repeat (8) @(posedge hclk);
    rc(8'h18, 32'h2, 32'h0);
    // Reset in mid-run clears enables and service state
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(8'h00, 32'hFFFFFFFF, 32'h0);
    rc(8'h20, 32'hFFFFFFFF, 32'h0);
    close_out();
  end
endmodule
